// ---- core/ddrm_port.sv ----
// Purpose: command decode, bank state and burst data path of a DDR module
// Assumes: CK is the link clock; each pin half-period is a separate port
// Notes: storage covers a small slice of rows and columns per bank
//
// Contract
// R01: two half-clock words per cycle, one core word
// R02: strobe driven by device only on reads
// R03: read strobe edge-aligned, write strobe centred
// R04: commands sampled on each rising CK edge
// R05: writes on both strobe edges, reads both
// R06: controller activates a row before access
// R07: activate picks bank and row A0-A12
// R08: read/write picks bank and start column
// R09: burst walks programmed length and order
// R10: burst length two, four or eight
// R11: auto precharge closes row after burst
// R12: four banks, independent open and close
// R13: 72-bit path, 64 data plus 8 check
// R14: auto refresh command and power-down state
// R15: select high masks every command
// R16: A10 requests auto precharge, or all-bank close
// R17: masked bytes stay unwritten on writes
// R18: controller accesses open rows, precharges first
`timescale 1ns/1ps
module ddrm_port #(
  parameter int ROW_STORE_BITS = 2,
  parameter int COL_STORE_BITS = 4
) (
  input wire logic CLK, // System clock
  input wire logic SYS_RST, // Synchronous reset, high
  input wire logic CK, // Link clock from controller
  input wire logic CKE, // Clock enable, low for power-down
  input wire logic CS_N, // Rank select, low
  input wire logic RAS_N, // Row strobe, low
  input wire logic CAS_N, // Column strobe, low
  input wire logic WE_N, // Write enable, low
  input wire logic [1:0] BA, // Bank address
  input wire logic [12:0] ADDR, // Row, column and A10
  input wire logic [71:0] DQ_I_RISE, // Write data, first half
  input wire logic [71:0] DQ_I_FALL, // Write data, second half
  input wire logic [8:0] DM_RISE, // Byte mask, first half
  input wire logic [8:0] DM_FALL, // Byte mask, second half
  input wire logic [8:0] DQS_I, // Strobe seen from controller
  output logic [71:0] DQ_O_RISE, // Read data, first half
  output logic [71:0] DQ_O_FALL, // Read data, second half
  output logic DQ_OE, // Data drive enable
  output logic [8:0] DQS_O, // Strobe level, first half
  output logic DQS_OE, // Strobe drive enable
  output logic [3:0] STAT_BANK_OPEN, // Open banks, system domain
  output logic STAT_POWER_DOWN, // Power-down, system domain
  output logic STAT_REFRESH // Refresh pulse, system domain
);
  localparam int IDX_W = 2 + ROW_STORE_BITS + COL_STORE_BITS;
  localparam int DEPTH = 1 << IDX_W;

  ddrm_pkg::ddrm_link_t q;
  ddrm_pkg::ddrm_link_t d;
  logic rst_s1;
  logic lrst;
  logic [2:0] cmd;
  logic cmd_ok;
  logic act_ok;
  logic rd_ok;
  logic wr_ok;
  logic pre_ok;
  logic ref_ok;
  logic xfer;
  logic done;
  logic [10:0] col0;
  logic [10:0] col1;
  logic [IDX_W-1:0] ix0;
  logic [IDX_W-1:0] ix1;
  logic [71:0] rd0;
  logic [71:0] rd1;

  ////////////////////////////////////////////////////////////////
  // Burst column for location i of the block
  function automatic logic [10:0] burst_col(input logic [10:0] s, input logic [2:0] i,
                                            input logic [2:0] m, input logic il);
    logic [2:0] lo;
    lo = il ? (s[2:0] ^ i) : 3'(s[2:0] + i);
    return (s & ~{8'h00, m}) | {8'h00, lo & m};
  endfunction

  // Storage index of a column in the burst bank
  function automatic logic [IDX_W-1:0] store_ix(input logic [1:0] b, input logic [12:0] r,
                                                input logic [10:0] c);
    return {b, r[ROW_STORE_BITS-1:0], c[COL_STORE_BITS-1:0]};
  endfunction

  ////////////////////////////////////////////////////////////////
  // Reset carried into the link domain
  always_ff @(posedge CK) begin
    rst_s1 <= SYS_RST;
    lrst <= rst_s1;
  end

  ////////////////////////////////////////////////////////////////
  // Command qualification
  assign cmd = {RAS_N, CAS_N, WE_N};
  assign cmd_ok = !CS_N && CKE && !q.pd; // [R15] [R04] [R14]
  assign act_ok = cmd_ok && cmd == ddrm_pkg::CMD_ACTIVATE;
  assign rd_ok = cmd_ok && cmd == ddrm_pkg::CMD_READ && q.open[BA] && !q.busy;
  assign wr_ok = cmd_ok && cmd == ddrm_pkg::CMD_WRITE && q.open[BA] && !q.busy;
  assign pre_ok = cmd_ok && cmd == ddrm_pkg::CMD_PRECHARGE;
  assign ref_ok = cmd_ok && cmd == ddrm_pkg::CMD_REFRESH && q.open == '0;

  // Current pair of burst locations
  assign xfer = q.busy && q.wait_n == 2'h1;
  assign done = xfer && 3'(q.idx + 3'h1) == q.blen_mask; // [R10]
  assign col0 = burst_col(q.col, q.idx, q.blen_mask, q.interleave); // [R09]
  assign col1 = burst_col(q.col, 3'(q.idx + 3'h1), q.blen_mask, q.interleave); // [R09]
  assign ix0 = store_ix(q.bank, q.row[q.bank], col0);
  assign ix1 = store_ix(q.bank, q.row[q.bank], col1);

  ////////////////////////////////////////////////////////////////
  // Byte lane storage, written on both strobe halves
  for (genvar b = 0; b < ddrm_pkg::LANES; b++) begin : g_lane // [R13]
    logic [7:0] lane [DEPTH];
    logic we_r;
    logic we_f;
    // A lane is written only when unmasked and its strobe arrived
    assign we_r = xfer && q.is_wr && !DM_RISE[b] && DQS_I[b]; // [R17] [R05]
    assign we_f = xfer && q.is_wr && !DM_FALL[b] && DQS_I[b]; // [R17] [R05]
    always_ff @(posedge CK) begin
      if (we_r) begin
        lane[ix0] <= DQ_I_RISE[b*8 +: 8];
      end
      if (we_f) begin
        lane[ix1] <= DQ_I_FALL[b*8 +: 8];
      end
    end
    assign rd0[b*8 +: 8] = lane[ix0];
    assign rd1[b*8 +: 8] = lane[ix1];
  end

  ////////////////////////////////////////////////////////////////
  // Next state of the link logic
  always_comb begin
    d = q;
    d.oe = 1'b0;
    // Power-down entry only with no burst running
    if (!CKE && !q.busy) begin
      d.pd = 1'b1; // [R14]
    end else if (CKE) begin
      d.pd = 1'b0;
    end
    // Burst progress, one word pair per clock
    if (q.busy) begin
      if (q.wait_n > 2'h1) begin
        d.wait_n = 2'(q.wait_n - 2'h1);
      end else begin
        d.idx = 3'(q.idx + 3'h2);
        if (!q.is_wr) begin
          d.dq_rise = rd0; // [R01]
          d.dq_fall = rd1; // [R01]
          d.oe = 1'b1; // [R02]
        end
        if (done) begin
          d.busy = 1'b0;
          if (q.auto_pre) begin
            d.open[q.bank] = 1'b0; // [R11]
          end
        end
      end
    end
    // Activate and precharge act on BA alone, except precharge with A10 set closes all banks
    if (act_ok) begin
      d.open[BA] = 1'b1; // [R07] [R12]
      d.row[BA] = ADDR; // [R07]
    end
    if (pre_ok) begin
      if (ADDR[ddrm_pkg::AUTO_PRE_BIT]) begin
        d.open = '0; // [R16]
      end else begin
        d.open[BA] = 1'b0; // [R16] [R12]
      end
    end
    // Read or write starts a burst at the given column
    if (rd_ok || wr_ok) begin
      d.busy = 1'b1;
      d.is_wr = wr_ok;
      d.bank = BA; // [R08]
      d.col = {ADDR[11], ADDR[9:0]}; // [R08]
      d.idx = 3'h0;
      d.auto_pre = ADDR[ddrm_pkg::AUTO_PRE_BIT]; // [R16] [R11]
      d.wait_n = wr_ok ? ddrm_pkg::WRITE_LAT_CYC : ddrm_pkg::READ_LAT_CYC;
    end
    if (ref_ok) begin
      d.ref_tog = !q.ref_tog; // [R14]
    end
    // Mode load sets burst length and order
    if (cmd_ok && cmd == ddrm_pkg::CMD_MODE && BA == 2'h0 && !q.busy) begin
      d.interleave = ADDR[ddrm_pkg::MODE_TYPE_BIT];
      unique case (ADDR[2:0])
        ddrm_pkg::BLEN_CODE_2: d.blen_mask = ddrm_pkg::BLEN_MASK_2; // [R10]
        ddrm_pkg::BLEN_CODE_4: d.blen_mask = ddrm_pkg::BLEN_MASK_4; // [R10]
        ddrm_pkg::BLEN_CODE_8: d.blen_mask = ddrm_pkg::BLEN_MASK_8; // [R10]
        default: d.blen_mask = q.blen_mask;
      endcase
    end
  end

  // Register the link state
  always_ff @(posedge CK) begin
    if (lrst) begin
      q <= '0;
      q.blen_mask <= ddrm_pkg::BLEN_MASK_RST;
      q.interleave <= ddrm_pkg::INTERLEAVE_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin drive; strobe high in first half, edge-aligned with data
  assign DQ_O_RISE = q.dq_rise;
  assign DQ_O_FALL = q.dq_fall;
  assign DQ_OE = q.oe; // [R02]
  assign DQS_O = {ddrm_pkg::LANES{q.oe}}; // [R03]
  assign DQS_OE = q.oe; // [R02] [R03]

  ////////////////////////////////////////////////////////////////
  // Status into the system domain
  ddrm_stat_sync u_stat (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .lnk_open(q.open),
    .lnk_pd(q.pd),
    .lnk_ref_tog(q.ref_tog),
    .bank_open(STAT_BANK_OPEN),
    .power_down(STAT_POWER_DOWN),
    .refresh_pulse(STAT_REFRESH)
  );

  ////////////////////////////////////////////////////////////////
  // Checks on the link domain
  default clocking @(posedge CK); endclocking
  default disable iff (lrst);

  a_select_masks: assert property ( // [R15]
    (CS_N && !q.busy) |=> $stable(q.open) && !q.busy)
    else $error("command taken with select high");

  a_act_opens: assert property ( // [R07]
    act_ok |=> q.open[$past(BA)] && q.row[$past(BA)] == $past(ADDR))
    else $error("activate did not open row");

  a_read_latency: assert property ( // [R05]
    rd_ok |=> !DQ_OE ##1 !DQ_OE ##1 DQ_OE)
    else $error("read data not at latency");

  a_write_no_drive: assert property ( // [R02]
    (q.busy && q.is_wr) |-> !DQ_OE && !DQS_OE)
    else $error("device drove during write");

  a_strobe_data: assert property ( // [R03]
    DQS_OE == DQ_OE && (!DQ_OE || DQS_O == 9'h1ff))
    else $error("strobe not with read data");

  a_auto_pre_close: assert property ( // [R11]
    (rd_ok && ADDR[10] && q.blen_mask == 3'h1) |-> ##3 !q.open[$past(BA, 3)])
    else $error("auto precharge did not close");

  a_pre_all: assert property ( // [R16]
    (pre_ok && ADDR[10] && !act_ok) |=> q.open == 4'h0)
    else $error("precharge all left bank open");

  a_burst_len: assert property ( // [R10]
    (rd_ok && q.blen_mask == 3'h7) |-> ##3 DQ_OE [*4] ##1 !DQ_OE)
    else $error("burst of eight wrong length");

  a_refresh_tog: assert property ( // [R14]
    ref_ok |=> q.ref_tog != $past(q.ref_tog))
    else $error("refresh not recorded");
endmodule

// ---- shared/ddrm_pkg.sv ----
// Purpose: constants and state types for the module command and data port
// Assumes: one word is 64 data bits plus 8 check bits, nine byte lanes
// Notes: command codes are {ras_n, cas_n, we_n} with select low
package ddrm_pkg;
  localparam int DATA_W = 72;
  localparam int LANES = 9;
  localparam int BANKS = 4;
  localparam int ROW_W = 13;
  localparam int COL_W = 11;
  localparam int ADDR_W = 13;

  // Command codes
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // Address bit positions
  localparam int AUTO_PRE_BIT = 10;
  localparam int MODE_TYPE_BIT = 3;

  // Burst length codes and location masks
  localparam logic [2:0] BLEN_CODE_2 = 3'h1;
  localparam logic [2:0] BLEN_CODE_4 = 3'h2;
  localparam logic [2:0] BLEN_CODE_8 = 3'h3;
  localparam logic [2:0] BLEN_MASK_2 = 3'h1;
  localparam logic [2:0] BLEN_MASK_4 = 3'h3;
  localparam logic [2:0] BLEN_MASK_8 = 3'h7;

  // Reset values
  localparam logic [2:0] BLEN_MASK_RST = 3'h1;
  localparam logic INTERLEAVE_RST = 1'b0;

  // Timing counts in link clocks
  localparam logic [1:0] READ_LAT_CYC = 2'h2;
  localparam logic [1:0] WRITE_LAT_CYC = 2'h1;

  // Link domain state
  typedef struct packed {
    logic [BANKS-1:0] open;
    logic [BANKS-1:0][ROW_W-1:0] row;
    logic [2:0] blen_mask;
    logic interleave;
    logic pd;
    logic ref_tog;
    logic busy;
    logic is_wr;
    logic auto_pre;
    logic [1:0] wait_n;
    logic [2:0] idx;
    logic [1:0] bank;
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] dq_rise;
    logic [DATA_W-1:0] dq_fall;
    logic oe;
  } ddrm_link_t;

  // System domain state
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic tog_seen;
    logic [3:0] open;
    logic pd;
    logic ref_p;
  } ddrm_stat_t;
endpackage

// ---- core/ddrm_stat_sync.sv ----
// Purpose: carry link status into the system clock domain
// Assumes: levels change slowly against the system clock
// Notes: refresh events arrive as a toggle and leave as a pulse
`timescale 1ns/1ps
module ddrm_stat_sync (
  input wire logic CLK, // System clock
  input wire logic SYS_RST, // Synchronous reset, high
  input wire logic [3:0] lnk_open, // Bank open levels, link domain
  input wire logic lnk_pd, // Power-down level, link domain
  input wire logic lnk_ref_tog, // Refresh toggle, link domain
  output logic [3:0] bank_open, // Synchronised bank open flags
  output logic power_down, // Synchronised power-down flag
  output logic refresh_pulse // One pulse per refresh
);
  ddrm_pkg::ddrm_stat_t st_q;
  ddrm_pkg::ddrm_stat_t st_d;

  ////////////////////////////////////////////////////////////////
  // Two stages, then decode from the second stage only
  always_comb begin
    st_d = st_q;
    st_d.s1 = {lnk_ref_tog, lnk_pd, lnk_open};
    st_d.s2 = st_q.s1;
    st_d.tog_seen = st_q.s2[5];
    st_d.open = st_q.s2[3:0];
    st_d.pd = st_q.s2[4];
    st_d.ref_p = st_q.s2[5] ^ st_q.tog_seen;
  end

  // Register the state
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bank_open = st_q.open;
  assign power_down = st_q.pd;
  assign refresh_pulse = st_q.ref_p;
endmodule

// ---- tb/ddrm_ctrl_model.sv ----
// Purpose: behavioural memory controller facing the module port
// Assumes: commands and data change on falling CK, sampled on rising CK
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
module ddrm_ctrl_model (
  input wire logic CK, // Link clock
  output logic CKE, // Clock enable
  output logic CS_N, // Rank select, low
  output logic RAS_N, // Row strobe, low
  output logic CAS_N, // Column strobe, low
  output logic WE_N, // Write enable, low
  output logic [1:0] BA, // Bank address
  output logic [12:0] ADDR, // Address lines
  output logic [71:0] DQ_I_RISE, // Write data, first half
  output logic [71:0] DQ_I_FALL, // Write data, second half
  output logic [8:0] DM_RISE, // Byte mask, first half
  output logic [8:0] DM_FALL, // Byte mask, second half
  output logic [8:0] DQS_I // Write strobe per lane
);
  ////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    CKE = 1'b1;
    {CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
    BA = 2'h0;
    ADDR = 13'h0000;
    {DQ_I_RISE, DQ_I_FALL, DM_RISE, DM_FALL, DQS_I} = '0;
  end

  // One command held across one rising edge, then deselect
  task automatic cmd(input logic cs_n, input logic [2:0] c, input logic [1:0] ba,
                     input logic [12:0] a);
    @(negedge CK);
    {CS_N, RAS_N, CAS_N, WE_N} = {cs_n, c};
    BA = ba;
    ADDR = a;
    @(negedge CK);
    {CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
    BA = ~ba;
    ADDR = ~a;
  endtask

  // One write pair with strobe centred in the cycle
  task automatic pair(input logic [71:0] r, input logic [71:0] f, input logic [8:0] m);
    DQ_I_RISE = r;
    DQ_I_FALL = f;
    DM_RISE = m;
    DM_FALL = 9'h000;
    DQS_I = 9'h1ff;
    @(negedge CK);
  endtask

  // Release data and strobe after a write burst
  task automatic idle();
    DQ_I_RISE = ~DQ_I_RISE;
    DQ_I_FALL = ~DQ_I_FALL;
    DQS_I = 9'h000;
  endtask
endmodule

// ---- tb/ddrm_port_bench.sv ----
// Purpose: self-checking bench for the module command and data port
// Assumes: controller model drives the link side
// Notes: bench keeps its own copy of the first sixteen columns of bank one
`timescale 1ns/1ps
module ddrm_port_bench;
  typedef struct packed {
    logic [2:0] code;
    logic il;
    logic [10:0] start;
    int pairs;
  } ddrm_row_t;
  logic CLK, SYS_RST, CK, CKE, CS_N, RAS_N, CAS_N, WE_N, DQ_OE, DQS_OE;
  logic STAT_POWER_DOWN, STAT_REFRESH, seen;
  logic [1:0] BA;
  logic [12:0] ADDR;
  logic [71:0] DQ_I_RISE, DQ_I_FALL, DQ_O_RISE, DQ_O_FALL;
  logic [8:0] DM_RISE, DM_FALL, DQS_I, DQS_O;
  logic [3:0] STAT_BANK_OPEN;
  logic [71:0] mem [16];
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  ddrm_row_t rows [6] = '{'{3'h1, 1'b0, 11'h001, 1}, '{3'h2, 1'b0, 11'h001, 2},
    '{3'h2, 1'b1, 11'h003, 2}, '{3'h3, 1'b0, 11'h005, 4}, '{3'h3, 1'b1, 11'h006, 4},
    '{3'h3, 1'b1, 11'h003, 4}};

  ////////////////////////////////////////////////////////////////////////
  ddrm_port #(.ROW_STORE_BITS(2), .COL_STORE_BITS(4)) i_ddrm_port (.CLK(CLK),
    .SYS_RST(SYS_RST), .CK(CK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
    .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .DQ_I_RISE(DQ_I_RISE), .DQ_I_FALL(DQ_I_FALL),
    .DM_RISE(DM_RISE), .DM_FALL(DM_FALL), .DQS_I(DQS_I), .DQ_O_RISE(DQ_O_RISE),
    .DQ_O_FALL(DQ_O_FALL), .DQ_OE(DQ_OE), .DQS_O(DQS_O), .DQS_OE(DQS_OE),
    .STAT_BANK_OPEN(STAT_BANK_OPEN), .STAT_POWER_DOWN(STAT_POWER_DOWN),
    .STAT_REFRESH(STAT_REFRESH));
  ddrm_ctrl_model i_ddrm_ctrl_model (.CK(CK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
    .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .DQ_I_RISE(DQ_I_RISE),
    .DQ_I_FALL(DQ_I_FALL), .DM_RISE(DM_RISE), .DM_FALL(DM_FALL), .DQS_I(DQS_I));

  // System and link clocks, unrelated in phase
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  initial begin
    CK = 1'b0;
    #3;
    forever #6 CK = ~CK;
  end

  // Hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst location order
  function automatic logic [10:0] loc(input logic [10:0] s, input int i, input int bl,
                                      input logic il);
    logic [10:0] m;
    m = 11'(bl - 1);
    return il ? (s ^ 11'(i)) : ((s & ~m) | ((s + 11'(i)) & m));
  endfunction

  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Sequential write to bank one, rise half masked by dm
  task automatic wr(input logic [10:0] s, input int bl, input logic [8:0] dm,
                    input logic [71:0] d);
    logic [3:0] a, b;
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_WRITE, 2'h1, {3'h0, s[9:0]});
    for (int p = 0; p < bl / 2; p++) begin
      a = 4'(loc(s, 2 * p, bl, 1'b0));
      b = 4'(loc(s, 2 * p + 1, bl, 1'b0));
      i_ddrm_ctrl_model.pair(d + 72'(a), d + 72'(b), dm);
      for (int k = 0; k < 9; k++)
        if (!dm[k]) mem[a][8*k+:8] = 8'(d + 72'(a) >> (8 * k));
      mem[b] = d + 72'(b);
    end
    i_ddrm_ctrl_model.idle();
  endtask

  // Read from bank one and compare each pair in burst order
  task automatic rd(input logic [10:0] s, input int bl, input logic il, input logic ap);
    int k;
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_READ, 2'h1, {2'h0, ap, s[9:0]});
    for (k = 0; k < 8 && DQ_OE !== 1'b1; k++) @(negedge CK);
    chk("latency", 72'(2), 72'(k));
    for (k = 0; k < bl / 2; k++) begin
      chk("rise", mem[4'(loc(s, 2 * k, bl, il))], DQ_O_RISE);
      chk("fall", mem[4'(loc(s, 2 * k + 1, bl, il))], DQ_O_FALL);
      chk("strobe", 72'h3ff, {62'h0, DQS_OE, DQS_O});
      @(negedge CK);
    end
    chk("oe_end", 72'h0, 72'(DQ_OE));
  endtask

  // Open-bank status, read only after it has crossed into the system domain
  task automatic stat(input string n, input logic [3:0] e);
    repeat (10) @(negedge CLK);
    chk(n, 72'(e), 72'(STAT_BANK_OPEN));
  endtask

  task conclude();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    SYS_RST = 1'b1;
    repeat (16) @(negedge CLK);
    SYS_RST = 1'b0;
    chk("rst_oe", 72'h0, {70'h0, DQ_OE, DQS_OE});
    stat("rst_stat", 4'h0);
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_MODE, 2'h0, 13'h0003);
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_ACTIVATE, 2'h1, 13'h1005);
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_ACTIVATE, 2'h2, 13'h0002);
    stat("open", 4'h6);
    wr(11'h000, 8, 9'h000, 72'h12_3456_789a_bcde_f000);
    foreach (rows[i]) begin
      i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_MODE, 2'h0, {9'h000, rows[i].il,
        rows[i].code});
      rd(rows[i].start, 2 * rows[i].pairs, rows[i].il, 1'b0);
    end
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_MODE, 2'h0, 13'h0001);
    wr(11'h002, 2, 9'h001, 72'hff_eedd_ccbb_aa99_8800);
    rd(11'h002, 2, 1'b0, 1'b0);
    i_ddrm_ctrl_model.cmd(1'b1, ddrm_pkg::CMD_READ, 2'h1, 13'h0000);
    repeat (2) @(negedge CK);
    chk("deselect", 72'h0, 72'(DQ_OE));
    rd(11'h000, 2, 1'b0, 1'b1);
    stat("auto_pre", 4'h4);
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_PRECHARGE, 2'h0, 13'h0400);
    stat("pre_all", 4'h0);
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_REFRESH, 2'h0, 13'h0000);
    seen = 1'b0;
    repeat (20) @(negedge CLK) seen = seen | STAT_REFRESH;
    chk("refresh", 72'h1, 72'(seen));
    @(negedge CK);
    i_ddrm_ctrl_model.CKE = 1'b0;
    i_ddrm_ctrl_model.cmd(1'b0, ddrm_pkg::CMD_ACTIVATE, 2'h3, 13'h0001);
    stat("pd_open", 4'h0);
    chk("pd", 72'h1, 72'(STAT_POWER_DOWN));
    conclude();
  end
endmodule
